/* File: rtl/bchs_regs.v */
// Bridge header status flags, class code, cache line and bus numbers
// as an AHB-Lite register slave on hclk.
// Assumes event pulses come from logic on hclk and need no synchroniser,
// and that the bus carries only single whole-word transfers.
//
// Behaviour
// - Interrupt pending status bit always reads zero
// - Capabilities list bit reads one after reset
// - 66MHz, fast back-to-back, select timing read zero
// - Master data parity flag set on requester parity
// - Master parity flag never set without response enable
// - Signaled target abort set on sent completer abort
// - Received master abort set on unsupported request completion
// - System error flag set on error message, enable
// - Detected parity flag set on poisoned TLP
// - Class code reads 06h, 04h, 00h
// - Cache line size byte plain read-write, no effect
// - Primary latency timer byte reads zero always
// - Header type byte reads 01h
// - Upstream bus number read-write, resets 00h
// - Downstream bus number read-write, resets 00h
// - Highest bus number read-write, resets 00h
// - Revision byte fixed, writes ignored
// - Parity error response enable at control bit 6
// - System error enable at control bit 8
`timescale 1ns/10ps
`include "bchs_map.vh"

module bchs_regs
#(
  parameter [7:0] SILICON_REV = 8'h01 // Arbitrary revision value
)
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Status events, one-cycle pulses from the port logic
  input wire ev_req_parity_err,
  input wire ev_cpl_abort_sent,
  input wire ev_cpl_abort_rcvd,
  input wire ev_cpl_unsup_rcvd,
  input wire ev_err_msg_sent,
  input wire ev_poisoned_rcvd,
  // Controls seen by the port logic
  output reg parity_resp_en,
  output reg sys_err_en,
  output reg [7:0] upstream_bus_number,
  output reg [7:0] downstream_bus_number,
  output reg [7:0] highest_bus_number
);

  // Transfer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_READ = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] addr_r;
  reg mdpe_r;
  reg sta_r;
  reg rta_r;
  reg rma_r;
  reg sse_r;
  reg dpe_r;
  reg [7:0] cache_line_size_r;
  wire take;
  wire wr_cmd;
  wire wr_cls;
  wire wr_bus;
  wire [31:0] status_word;
  wire [31:0] rd_word;
  // Set and clear terms of the write-one-to-clear flags
  wire mdpe_set;
  wire mdpe_clr;
  wire sse_set;
  wire sse_clr;
  wire dpe_set;
  wire dpe_clr;
  // Next values of the flags, controls and read-write bytes
  reg mdpe_nxt;
  reg sta_nxt;
  reg rta_nxt;
  reg rma_nxt;
  reg sse_nxt;
  reg dpe_nxt;
  reg parity_resp_en_nxt;
  reg sys_err_en_nxt;
  reg [7:0] cache_line_size_nxt;
  reg [7:0] upstream_bus_number_nxt;
  reg [7:0] downstream_bus_number_nxt;
  reg [7:0] highest_bus_number_nxt;
  // Fixed and stored words as they read back
  wire [31:0] rev_cls_word;
  wire [31:0] cls_hdr_word;
  wire [31:0] busnum_word;
  // Fixed status bits; constants so that writes cannot reach them
  wire sts_int_pend;
  wire sts_cap_list;
  wire sts_66mhz;
  wire sts_reserved22;
  wire sts_fast_b2b;
  wire [1:0] sts_sel_timing;
  wire [2:0] sts_reserved_lo;
  // The two halves of the status word
  wire [15:0] ctl_half;
  wire [15:0] sts_half;

  // Sticky flag with write-one-to-clear; a set in the clearing cycle wins
  function upd_w1c;
    input cur;
    input set;
    input clr;
    begin
      upd_w1c = (cur & ~clr) | set;
    end
  endfunction

  // Word read value for a given offset; unmapped offsets read zero
  function [31:0] rd_mux;
    input [7:0] off;
    input [31:0] sts;
    begin
      case (off)
        `BCHS_OFF_CMD_STS:
          rd_mux = sts;
        `BCHS_OFF_REV_CLS:
          rd_mux = rev_cls_word;
        `BCHS_OFF_CLS_HDR:
          rd_mux = cls_hdr_word;
        `BCHS_OFF_BUSNUM:
          rd_mux = busnum_word;
        default:
          rd_mux = `BCHS_ZERO_WORD;
      endcase
    end
  endfunction

  // Word offset match; the block mirrors every 256 bytes
  function at_off;
    input [7:0] cur;
    input [7:0] off;
    begin
      at_off = (cur == off);
    end
  endfunction

  // Class and header words, fixed but for cache_line_size_r; only the revision byte is a build choice
  assign rev_cls_word = {`BCHS_BASE_CLASS, `BCHS_SUB_CLASS,
                         `BCHS_PROG_IF, SILICON_REV};
  assign cls_hdr_word = {`BCHS_RESET_BYTE, `BCHS_HDR_TYPE,
                         `BCHS_LAT_TIMER, cache_line_size_r};
  // Top byte of the bus number word is reserved and reads zero
  assign busnum_word = {`BCHS_RESET_BYTE, highest_bus_number,
                        downstream_bus_number, upstream_bus_number};

  // Address phase accepted while the bus is ready
  assign take = hsel & htrans[1] & hready;

  // Write strobes during the write data phase
  assign wr_cmd = state_r[1] & at_off(addr_r, `BCHS_OFF_CMD_STS);
  assign wr_cls = state_r[1] & at_off(addr_r, `BCHS_OFF_CLS_HDR);
  assign wr_bus = state_r[1] & at_off(addr_r, `BCHS_OFF_BUSNUM);

  // Fixed status bits; legacy bus timing has no meaning on a serial link
  assign sts_int_pend = 1'b0;
  assign sts_cap_list = 1'b1;
  assign sts_66mhz = 1'b0;
  assign sts_reserved22 = 1'b0;
  assign sts_fast_b2b = 1'b0;
  assign sts_sel_timing = 2'b00;
  assign sts_reserved_lo = 3'b000;

  // Status half over the control half
  assign sts_half = {dpe_r, sse_r, rma_r, rta_r, sta_r, sts_sel_timing,
                     mdpe_r, sts_fast_b2b, sts_reserved22, sts_66mhz,
                     sts_cap_list, sts_int_pend, sts_reserved_lo};
  assign ctl_half = {7'h00, sys_err_en, 1'b0, parity_resp_en, 6'h00};
  assign status_word = {sts_half, ctl_half};
  assign rd_word = rd_mux(addr_r, status_word);

  // MDPE and SSE set terms are gated by their enables, DPE is not; clears need a written one
  assign mdpe_set = ev_req_parity_err & parity_resp_en;
  assign mdpe_clr = wr_cmd & hwdata[`BCHS_STS_MDPE];
  assign sse_set = ev_err_msg_sent & sys_err_en;
  assign sse_clr = wr_cmd & hwdata[`BCHS_STS_SSE];
  assign dpe_set = ev_poisoned_rcvd;
  assign dpe_clr = wr_cmd & hwdata[`BCHS_STS_DPE];

  // Next flag values; abort bits only accumulate until reset
  always @*
  begin
    mdpe_nxt = upd_w1c(mdpe_r, mdpe_set, mdpe_clr);
    sse_nxt = upd_w1c(sse_r, sse_set, sse_clr);
    dpe_nxt = upd_w1c(dpe_r, dpe_set, dpe_clr);
    sta_nxt = sta_r | ev_cpl_abort_sent;
    rta_nxt = rta_r | ev_cpl_abort_rcvd;
    rma_nxt = rma_r | ev_cpl_unsup_rcvd;
  end

  // Next control and byte values; writes land in the data phase
  always @*
  begin
    parity_resp_en_nxt = parity_resp_en;
    sys_err_en_nxt = sys_err_en;
    cache_line_size_nxt = cache_line_size_r;
    upstream_bus_number_nxt = upstream_bus_number;
    downstream_bus_number_nxt = downstream_bus_number;
    highest_bus_number_nxt = highest_bus_number;
    if (wr_cmd)
    begin
      parity_resp_en_nxt = hwdata[`BCHS_CMD_PERR_EN];
      sys_err_en_nxt = hwdata[`BCHS_CMD_SERR_EN];
    end
    // Stored only for software; nothing else reads it
    if (wr_cls)
      cache_line_size_nxt = hwdata[`BCHS_B0];
    if (wr_bus)
    begin
      upstream_bus_number_nxt = hwdata[`BCHS_B0];
      downstream_bus_number_nxt = hwdata[`BCHS_B1];
      highest_bus_number_nxt = hwdata[`BCHS_B2];
    end
  end

  // Next transfer state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_WRITE:
      begin
        if (take)
          state_nxt = hwrite ? ST_WRITE : ST_READ;
        else
          state_nxt = ST_IDLE;
      end
      ST_READ:
        state_nxt = ST_IDLE; // Wait cycle ends, hreadyout returns high
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Bus handshake; reads take one wait state so that a read right after
  // a write returns the freshly written value
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= `BCHS_HRESP_OKAY;
      hrdata <= `BCHS_ZERO_WORD;
    end
    else
    begin
      state_r <= state_nxt;
      hresp <= `BCHS_HRESP_OKAY;
      if (take && state_r != ST_READ)
        addr_r <= {haddr[7:2], 2'b00};
      if (state_nxt == ST_READ)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
      if (state_r == ST_READ)
        hrdata <= rd_word;
    end
  end

  // Control bits and plain read-write bytes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      parity_resp_en <= 1'b0;
      sys_err_en <= 1'b0;
      cache_line_size_r <= `BCHS_RESET_BYTE;
      upstream_bus_number <= `BCHS_RESET_BYTE;
      downstream_bus_number <= `BCHS_RESET_BYTE;
      highest_bus_number <= `BCHS_RESET_BYTE;
    end
    else
    begin
      parity_resp_en <= parity_resp_en_nxt;
      sys_err_en <= sys_err_en_nxt;
      cache_line_size_r <= cache_line_size_nxt;
      upstream_bus_number <= upstream_bus_number_nxt;
      downstream_bus_number <= downstream_bus_number_nxt;
      highest_bus_number <= highest_bus_number_nxt;
    end
  end

  // Sticky status flags; the abort bits clear only on reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mdpe_r <= 1'b0;
      sta_r <= 1'b0;
      rta_r <= 1'b0;
      rma_r <= 1'b0;
      sse_r <= 1'b0;
      dpe_r <= 1'b0;
    end
    else
    begin
      mdpe_r <= mdpe_nxt;
      sta_r <= sta_nxt;
      rta_r <= rta_nxt;
      rma_r <= rma_nxt;
      sse_r <= sse_nxt;
      dpe_r <= dpe_nxt;
    end
  end

endmodule // bchs_regs

/* File: shared/bchs_map.vh */
// Constants of the bridge header status and bus number register bank.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef BCHS_MAP_VH
`define BCHS_MAP_VH

// Word offsets on the register bus (byte addresses)
`define BCHS_OFF_CMD_STS 8'h04
`define BCHS_OFF_REV_CLS 8'h08
`define BCHS_OFF_CLS_HDR 8'h0C
`define BCHS_OFF_BUSNUM 8'h18

// Control bits in the low half of the status word
`define BCHS_CMD_PERR_EN 6
`define BCHS_CMD_SERR_EN 8

// Status bit positions in the upper half of the word
`define BCHS_STS_INT_PEND 19
`define BCHS_STS_CAP_LIST 20
`define BCHS_STS_MDPE 24
`define BCHS_STS_STA 27
`define BCHS_STS_RTA 28
`define BCHS_STS_RMA 29
`define BCHS_STS_SSE 30
`define BCHS_STS_DPE 31

// Fixed field values
`define BCHS_PROG_IF 8'h00
`define BCHS_SUB_CLASS 8'h04
`define BCHS_BASE_CLASS 8'h06
`define BCHS_LAT_TIMER 8'h00
`define BCHS_HDR_TYPE 8'h01
`define BCHS_RESET_BYTE 8'h00
`define BCHS_ZERO_WORD 32'h0000_0000

// Field positions inside the words
`define BCHS_B0 7:0
`define BCHS_B1 15:8
`define BCHS_B2 23:16
`define BCHS_B3 31:24

// Bus encodings
`define BCHS_HRESP_OKAY 1'b0

`endif

/* File: verification/bchs_cfg_master.sv */
// Configuration requester model: AHB-Lite master, single word transfers.
// Assumes hready is the one slave's hreadyout on the shared hclk.
`timescale 1ns/10ps
module bchs_cfg_master
(
  // Clock and answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0000_0000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0000_0000
);
  // Wait for hready high at an edge; bounded so a hang is reported
  task wt(output logic ok);
    int n;
    begin
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 16)
      begin
        n++;
        @(posedge hclk);
      end
      ok = hready === 1'b1;
    end
  endtask
  // Address phase, then data phase; stale write data is inverted
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    logic k;
    begin
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wt(ok);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt(k);
      q = hrdata;
      ok = ok & k;
      hwdata <= ~d;
    end
  endtask
endmodule // bchs_cfg_master

/* File: verification/bchs_regs_checker.sv */
// Bus timing and fixed-field checks for the header register bank.
// Assumes hready is tied to hreadyout and only low offsets are used.
`timescale 1ns/10ps
module bchs_regs_checker
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  // Controls
  input wire parity_resp_en,
  input wire sys_err_en,
  input wire [7:0] upstream_bus_number,
  input wire [7:0] downstream_bus_number,
  input wire [7:0] highest_bus_number
);
  logic [7:0] ra_r;
  wire tk = hsel && htrans[1] && hready;
  wire rw = tk && hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Offset of the read in flight, so read data can be judged
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ra_r <= 8'h00;
    else if (tk && !hwrite)
      ra_r <= haddr[7:0];
  a_rd_wait:
    assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_wr_nowait:
    assert property (rw |=> hreadyout) else $error("write stalled");
  a_sts_fixed:
    assert property ($rose(hreadyout) && ra_r == 8'h04 |->
      hrdata[23:16] == 8'h10 && hrdata[26:25] == 2'h0)
    else $error("fixed status bits wrong");
  a_class_code:
    assert property ($rose(hreadyout) && ra_r == 8'h08 |->
      hrdata[31:8] == 24'h06_0400) else $error("class code wrong");
  a_hdr_fixed:
    assert property ($rose(hreadyout) && ra_r == 8'h0C |->
      hrdata[31:8] == 24'h00_0100) else $error("header byte wrong");
  a_busnum_read:
    assert property ($rose(hreadyout) && ra_r == 8'h18 |-> hrdata ==
      {8'h00, highest_bus_number, downstream_bus_number,
      upstream_bus_number}) else $error("bus number read wrong");
  a_busnum_write:
    assert property (rw && haddr[7:0] == 8'h18 |=> ##1
      upstream_bus_number == $past(hwdata[7:0]) &&
      downstream_bus_number == $past(hwdata[15:8]) &&
      highest_bus_number == $past(hwdata[23:16]))
    else $error("bus number write lost");
  a_ctl_write:
    assert property (rw && haddr[7:0] == 8'h04 |=> ##1
      {sys_err_en, parity_resp_en} == $past({hwdata[8], hwdata[6]}))
    else $error("control write lost");
endmodule // bchs_regs_checker

bind bchs_regs bchs_regs_checker u_bchs_regs_checker (.*);

/* File: verification/bchs_regs_tb.sv */
// Self-checking bench for the header register bank.
// Assumes the bus model issues every request on one hclk domain.
`timescale 1ns/10ps
module bchs_regs_tb;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary revision value
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [31:0] q;
  int mismatches = 0;
  int samples_checked = 0;
  wire ev_req_parity_err = ev[0], ev_cpl_abort_sent = ev[1];
  wire ev_cpl_abort_rcvd = ev[2], ev_cpl_unsup_rcvd = ev[3];
  wire ev_err_msg_sent = ev[4], ev_poisoned_rcvd = ev[5];
  wire hsel, hwrite, hreadyout, hresp, parity_resp_en, sys_err_en;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [7:0] upstream_bus_number, downstream_bus_number;
  wire [7:0] highest_bus_number;
  wire hready = hreadyout; // Single slave owns bus ready
  wire [31:0] ctl = {6'h00, parity_resp_en, sys_err_en,
    highest_bus_number, downstream_bus_number, upstream_bus_number};
  // Writes: offset, data, expected read back
  logic [7:0] ta [5] = '{8'h18, 8'h0C, 8'h08, 8'h40, 8'h04};
  logic [31:0] tw [5] = '{32'hFFA5_3C12, 32'hFFFF_FF7E,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] te [5] = '{32'h00A5_3C12, 32'h0001_007E,
    {24'h06_0400, REV}, 32'h0000_0000, 32'h0010_0140};
  always #20 hclk = ~hclk;
  bchs_regs #(.SILICON_REV(REV)) u_bchs_regs (.*);
  bchs_cfg_master u_bchs_cfg_master (.*);
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      samples_checked++;
      if (s !== e)
      begin
        mismatches++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // A transfer that never completes ends the run
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] v);
    logic ok;
    begin
      u_bchs_cfg_master.xfer(w, a, d, v, ok);
      if (!ok)
      begin
        mismatches++;
        finish_test;
      end
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    begin
      bus(1'b0, a, 32'h0000_0000, v);
      chk(v, e);
    end
  endtask
  // One-cycle event pulses from the port logic
  task fire(input logic [5:0] m);
    begin
      ev <= m;
      @(posedge hclk);
      ev <= 6'h00;
      @(posedge hclk);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h04, 32'h0010_0000);
    rd(8'h08, {24'h06_0400, REV});
    rd(8'h0C, 32'h0001_0000);
    rd(8'h18, 32'h0000_0000);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, ta[i], tw[i], q);
      rd(ta[i], te[i]);
    end
    chk(ctl, 32'h03A5_3C12);
    $display("test write_read done");
    fire(6'h3F);
    rd(8'h04, 32'hF910_0140);
    bus(1'b1, 8'h04, 32'hC100_0140, q);
    rd(8'h04, 32'h3810_0140);
    bus(1'b1, 8'h04, 32'h0000_0000, q);
    fire(6'h3F);
    rd(8'h04, 32'hB810_0000);
    bus(1'b1, 8'h04, 32'hB800_0000, q);
    rd(8'h04, 32'h3810_0000);
    fork
      bus(1'b1, 8'h04, 32'h8000_0000, q);
      begin
        @(posedge hclk);
        ev <= 6'h20;
        @(posedge hclk);
        ev <= 6'h00;
      end
    join
    rd(8'h04, 32'hB810_0000);
    $display("test status_flags done");
    finish_test;
  end
endmodule // bchs_regs_tb
